// ---- include/ris_pkg.sv ----
// constants, field layouts and carrier types of the reader interrupt status block
// assumes a 32-bit classic wishbone slave, registers one word each at 4 x index
package ris_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] RIS_IDX_MAIN_MASK = 6'h16;
	localparam logic [5:0] RIS_IDX_TF_MASK = 6'h17;
	localparam logic [5:0] RIS_IDX_EW_MASK = 6'h18;
	localparam logic [5:0] RIS_IDX_PT_MASK = 6'h19;
	localparam logic [5:0] RIS_IDX_MAIN = 6'h1A;
	localparam logic [5:0] RIS_IDX_TF = 6'h1B;
	localparam logic [5:0] RIS_IDX_EW = 6'h1C;
	localparam logic [5:0] RIS_IDX_PT = 6'h1D;
	localparam logic [5:0] RIS_IDX_CTRL = 6'h30;

	// control register fields
	localparam int RIS_CTRL_OSC_RUN = 0;
	localparam int RIS_CTRL_WAKE_EVERY = 1;

	// fifo thresholds in bytes
	localparam logic [9:0] RIS_FIFO_RX_LEVEL = 10'h12C;
	localparam logic [9:0] RIS_FIFO_TX_LEVEL = 10'h0C8;

	// reset values
	localparam logic [7:0] RIS_FLAGS_RESET = 8'h00;
	localparam logic [7:0] RIS_MASK_RESET = 8'h00;
	localparam logic [7:0] RIS_CTRL_RESET = 8'h00;

	// reserved bits of the main, error/wake and target flag registers; timer/field has none
	localparam logic [7:0] RIS_MAIN_RSVD = 8'h01;
	localparam logic [7:0] RIS_EW_RSVD = 8'h01;
	localparam logic [7:0] RIS_PT_RSVD = 8'h04;

	// flag layouts, msb first, field order equals bit order
	typedef struct packed {
		logic clock_stable_flag;
		logic fifo_level_flag;
		logic receive_begin_flag;
		logic receive_done_flag;
		logic transmit_done_flag;
		logic bit_clash_flag;
		logic frame_restart_flag;
		logic rsvd0;
	} ris_main_type;

	typedef struct packed {
		logic command_done_flag;
		logic reply_timeout_flag;
		logic general_timer_flag;
		logic outside_field_up_flag;
		logic outside_field_down_flag;
		logic avoidance_clash_flag;
		logic guard_time_flag;
		logic target_rate_flag;
	} ris_tf_type;

	typedef struct packed {
		logic checksum_fail_flag;
		logic parity_fail_flag;
		logic soft_framing_flag;
		logic hard_framing_flag;
		logic wake_timer_flag;
		logic wake_amplitude_flag;
		logic wake_phase_flag;
		logic rsvd0;
	} ris_ew_type;

	typedef struct packed {
		logic field_wait_timer_flag;
		logic slot_pool_low_flag;
		logic peer_field_on_flag;
		logic auto_reply_receive_flag;
		logic fast_target_active_flag;
		logic rsvd2;
		logic target_active_star_flag;
		logic target_active_flag;
	} ris_pt_type;

	// event inputs from the rest of the device, same clock
	typedef struct packed {
		logic osc_stable;
		logic rx_active;
		logic tx_active;
		logic [9:0] fifo_count;
		logic wake_timeout;
		logic [7:0] slots_unused;
		ris_main_type main_ev;
		ris_tf_type tf_ev;
		ris_ew_type ew_ev;
		ris_pt_type pt_ev;
	} ris_events_type;

	localparam logic [7:0] RIS_SLOTS_LOW = 8'h04;

endpackage

// ---- design/ris_top.sv ----
// reader interrupt status block: four flag registers (error/wake clears on a main read, the rest on their own read), masks, irq
// assumes event pulses and levels come from logic on clk; host on classic wishbone
//
// Notes on behaviour
// [R1] oscillator stable sets main bit 7
// [R2] receiving, fifo above 300 sets level flag
// [R3] transmitting, fifo below 200 sets level flag
// [R4] emd frame discard sets main bit 1
// [R5] main bits 5..2 rx/tx/clash, bit 0 reserved
// [R6] reading timer/field or target register clears it
// [R7] reading main clears error/wake register
// [R8] host clears avoidance flag before collision avoidance
// [R9] guard time elapsed sets timer/field bit 1
// [R10] command, no-response, general timer bits 7..5
// [R11] outside field up bit 4, down bit 3
// [R12] target bit rate recognised sets bit 0
// [R13] host reads promptly to avoid checksum flag
// [R14] parity bit 6, soft framing 5, hard 4
// [R15] wake timeout flag only with every-timeout option
// [R16] amplitude bit 2, phase bit 1 on wake
// [R17] four unused slots left sets target bit 6
// [R18] peer field on sets target bit 5
// [R19] automatic anticollision reply sets target bit 4
// [R20] automatic fast response sent sets bit 3
// [R21] active star bit 1, active bit 0
// [R22] mask bit one blocks that event's irq
// [R23] irq high while any unmasked flag pending
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps

module ris_top
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// device events
	input wire ris_pkg::ris_events_type events,
	// interrupt request
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta_n_reg;
	logic rst_n_reg;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_n_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_n_reg <= 1'b1;
			rst_n_reg <= rst_meta_n_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [7:0] main_flags;
		logic [7:0] tf_flags;
		logic [7:0] ew_flags;
		logic [7:0] pt_flags;
		logic [7:0] main_mask;
		logic [7:0] tf_mask;
		logic [7:0] ew_mask;
		logic [7:0] pt_mask;
		logic [7:0] ctrl;
		logic osc_seen;
		logic fifo_cond;
		logic slots_low;
		logic ack;
		logic [31:0] rdat;
		logic irq;
	} ris_state_type;

	ris_state_type state_reg;
	ris_state_type state_next;

	logic take;
	logic [5:0] idx;
	logic osc_now;
	logic fifo_now;
	logic slots_now;
	logic [7:0] main_set;
	logic [7:0] tf_set;
	logic [7:0] ew_set;
	logic [7:0] pt_set;
	logic [7:0] rsel;
	ris_pkg::ris_main_type main_ev;
	ris_pkg::ris_ew_type ew_ev;
	ris_pkg::ris_pt_type pt_ev;

	always_comb
	begin
		state_next = state_reg;
		// one answer per request, acked the cycle after the request; ack drops the cycle after it is given
		take = wb_cyc_i && wb_stb_i && !state_reg.ack;
		idx = wb_adr_i[7:2];

		// level events become one set per rising edge, so a held level cannot re-set after a read
		osc_now = events.osc_stable && state_reg.ctrl[ris_pkg::RIS_CTRL_OSC_RUN]; // [R1]
		fifo_now = (events.rx_active && (events.fifo_count > ris_pkg::RIS_FIFO_RX_LEVEL)) // [R2]
			|| (events.tx_active && (events.fifo_count < ris_pkg::RIS_FIFO_TX_LEVEL)); // [R3]
		slots_now = (events.slots_unused == ris_pkg::RIS_SLOTS_LOW); // [R17]

		main_ev = events.main_ev; // [R4] [R5]
		main_ev.clock_stable_flag = osc_now && !state_reg.osc_seen; // [R1]
		main_ev.fifo_level_flag = fifo_now && !state_reg.fifo_cond; // [R2] [R3]
		main_ev.rsvd0 = 1'b0; // [R5]

		ew_ev = events.ew_ev; // [R14] [R16]
		ew_ev.wake_timer_flag = events.wake_timeout && state_reg.ctrl[ris_pkg::RIS_CTRL_WAKE_EVERY]; // [R15]
		ew_ev.rsvd0 = 1'b0;

		pt_ev = events.pt_ev; // [R18] [R19] [R20] [R21]
		pt_ev.slot_pool_low_flag = slots_now && !state_reg.slots_low; // [R17]
		pt_ev.rsvd2 = 1'b0;

		main_set = main_ev;
		tf_set = events.tf_ev; // [R9] [R10] [R11] [R12]
		ew_set = ew_ev;
		pt_set = pt_ev;

		state_next.osc_seen = osc_now;
		state_next.fifo_cond = fifo_now;
		state_next.slots_low = slots_now;

		// read mux; reserved bits and unmapped words read zero
		unique case (idx)
			ris_pkg::RIS_IDX_MAIN_MASK: rsel = state_reg.main_mask & ~ris_pkg::RIS_MAIN_RSVD;
			ris_pkg::RIS_IDX_TF_MASK: rsel = state_reg.tf_mask;
			ris_pkg::RIS_IDX_EW_MASK: rsel = state_reg.ew_mask & ~ris_pkg::RIS_EW_RSVD;
			ris_pkg::RIS_IDX_PT_MASK: rsel = state_reg.pt_mask & ~ris_pkg::RIS_PT_RSVD;
			ris_pkg::RIS_IDX_MAIN: rsel = state_reg.main_flags;
			ris_pkg::RIS_IDX_TF: rsel = state_reg.tf_flags;
			ris_pkg::RIS_IDX_EW: rsel = state_reg.ew_flags;
			ris_pkg::RIS_IDX_PT: rsel = state_reg.pt_flags;
			ris_pkg::RIS_IDX_CTRL: rsel = state_reg.ctrl;
			default: rsel = 8'h00;
		endcase

		state_next.ack = take;
		state_next.rdat = state_reg.rdat;

		// clear on read; a set in the same cycle survives
		state_next.main_flags = state_reg.main_flags;
		state_next.tf_flags = state_reg.tf_flags;
		state_next.ew_flags = state_reg.ew_flags;
		state_next.pt_flags = state_reg.pt_flags;
		if (take && !wb_we_i)
		begin
			state_next.rdat = {24'h000000, rsel};
			if (idx == ris_pkg::RIS_IDX_MAIN)
			begin
				state_next.main_flags = ris_pkg::RIS_FLAGS_RESET;
				state_next.ew_flags = ris_pkg::RIS_FLAGS_RESET; // [R7]
			end
			if (idx == ris_pkg::RIS_IDX_TF)
			begin
				state_next.tf_flags = ris_pkg::RIS_FLAGS_RESET; // [R6]
			end
			if (idx == ris_pkg::RIS_IDX_PT)
			begin
				state_next.pt_flags = ris_pkg::RIS_FLAGS_RESET; // [R6]
			end
		end
		else if (take)
		begin
			state_next.rdat = 32'h00000000;
		end
		// the avoidance flag is left to the host to clear first [R8]; late reads risk checksum [R13]
		state_next.main_flags = state_next.main_flags | main_set;
		state_next.tf_flags = state_next.tf_flags | tf_set;
		state_next.ew_flags = state_next.ew_flags | ew_set;
		state_next.pt_flags = state_next.pt_flags | pt_set;

		// writes only through byte lane 0; flag registers ignore writes
		if (take && wb_we_i && wb_sel_i[0])
		begin
			unique case (idx)
				ris_pkg::RIS_IDX_MAIN_MASK: state_next.main_mask = wb_dat_i[7:0];
				ris_pkg::RIS_IDX_TF_MASK: state_next.tf_mask = wb_dat_i[7:0];
				ris_pkg::RIS_IDX_EW_MASK: state_next.ew_mask = wb_dat_i[7:0];
				ris_pkg::RIS_IDX_PT_MASK: state_next.pt_mask = wb_dat_i[7:0];
				ris_pkg::RIS_IDX_CTRL: state_next.ctrl = wb_dat_i[7:0];
				default: state_next.ctrl = state_reg.ctrl;
			endcase
		end

		// irq follows the flags that will be held next cycle, so it tracks them without lag
		state_next.irq = |(state_next.main_flags & ~state_next.main_mask) // [R22] [R23]
			|| |(state_next.tf_flags & ~state_next.tf_mask)
			|| |(state_next.ew_flags & ~state_next.ew_mask)
			|| |(state_next.pt_flags & ~state_next.pt_mask);
	end

	always_ff @(posedge clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			state_reg.main_flags <= ris_pkg::RIS_FLAGS_RESET;
			state_reg.tf_flags <= ris_pkg::RIS_FLAGS_RESET;
			state_reg.ew_flags <= ris_pkg::RIS_FLAGS_RESET;
			state_reg.pt_flags <= ris_pkg::RIS_FLAGS_RESET;
			state_reg.main_mask <= ris_pkg::RIS_MASK_RESET;
			state_reg.tf_mask <= ris_pkg::RIS_MASK_RESET;
			state_reg.ew_mask <= ris_pkg::RIS_MASK_RESET;
			state_reg.pt_mask <= ris_pkg::RIS_MASK_RESET;
			state_reg.ctrl <= ris_pkg::RIS_CTRL_RESET;
			state_reg.osc_seen <= 1'b0;
			state_reg.fifo_cond <= 1'b0;
			state_reg.slots_low <= 1'b0;
			state_reg.ack <= 1'b0;
			state_reg.rdat <= 32'h00000000;
			state_reg.irq <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign wb_dat_o = state_reg.rdat;
	assign wb_ack_o = state_reg.ack;
	assign irq = state_reg.irq;

endmodule // ris_top

// ---- bench/ris_top_sva.sv ----
// checker of the reader interrupt status block
// assumes the master holds its request through the ack cycle
`timescale 1ns/1ps
module ris_top_sva
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// events and irq
	input wire ris_pkg::ris_events_type events,
	input wire logic irq
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
logic [7:0] tfm_reg;
// copy taken at ack; bench keeps events off that cycle
always_ff @(posedge clk or negedge nrst)
	if (!nrst)
		tfm_reg <= 8'h00;
	else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == ris_pkg::RIS_IDX_TF_MASK)
		tfm_reg <= wb_dat_i[7:0];
////////////////
sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
sequence s_rd(i); wb_ack_o && !wb_we_i && wb_adr_i[7:2] == i; endsequence
property p_take; s_take |=> wb_ack_o; endproperty
a_take: assert property (p_take) else $error("no ack");
property p_one; wb_ack_o |=> !wb_ack_o; endproperty
a_one: assert property (p_one) else $error("ack too long");
property p_cause; wb_ack_o |-> $past(wb_stb_i); endproperty
a_cause: assert property (p_cause) else $error("ack without request");
property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
a_upper: assert property (p_upper) else $error("upper data set");
property p_main_rsvd; s_rd(ris_pkg::RIS_IDX_MAIN) |-> !wb_dat_o[0]; endproperty
a_main_rsvd: assert property (p_main_rsvd) else $error("main bit 0 set");
property p_ew_rsvd; s_rd(ris_pkg::RIS_IDX_EW) |-> !wb_dat_o[0]; endproperty
a_ew_rsvd: assert property (p_ew_rsvd) else $error("error bit 0 set");
property p_pt_rsvd; s_rd(ris_pkg::RIS_IDX_PT) |-> !wb_dat_o[2]; endproperty
a_pt_rsvd: assert property (p_pt_rsvd) else $error("target bit 2 set");
property p_irq; |(events.tf_ev & ~tfm_reg) |=> irq; endproperty
a_irq: assert property (p_irq) else $error("irq missing");
property p_drop; $fell(irq) |-> wb_ack_o; endproperty
a_drop: assert property (p_drop) else $error("irq fell without access");
endmodule // ris_top_sva
bind ris_top ris_top_sva u_sva (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .events, .irq);

// ---- bench/ris_host.sv ----
// host model: classic wishbone master with one access task
// assumes a slave that acks every request
`timescale 1ns/1ps
module ris_host
(
	// clock
	input wire logic clk,
	// bus
	output logic wb_cyc_i,
	output logic wb_stb_i,
	output logic wb_we_i,
	output logic [7:0] wb_adr_i,
	output logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
// reads come promptly, so flags are cleared before new sequences
task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
	@(posedge clk);
	{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, 24'h000000, d};
	@(posedge clk);
	while (!wb_ack_o)
		@(posedge clk);
	q = wb_dat_o[7:0];
	// released address and data lines show the inverse, not the last value; we and sel keep the last value
	{wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} <= {2'b00, ~wb_adr_i, ~wb_dat_i};
endtask
endmodule // ris_host

// ---- bench/ris_top_test.sv ----
// self-checking bench of the reader interrupt status block
// assumes the host model owns the bus; this module drives events
`timescale 1ns/1ps
module ris_top_test;
logic clk = 1'b0;
logic nrst = 1'b0;
logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
logic [7:0] wb_adr_i;
logic [3:0] wb_sel_i;
logic [31:0] wb_dat_i, wb_dat_o;
ris_pkg::ris_events_type events = '0;
int n_errors = 0;
int comparisons = 0;
int cycles = 0;
always #2.5 clk = ~clk;
ris_top u_dut (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .events, .irq);
ris_host u_host (.clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o);
////////////////
task automatic end_sim;
	$display("comparisons %0d mismatches %0d", comparisons, n_errors);
	if (n_errors == 0 && comparisons > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task automatic chk(input logic [7:0] s, input logic [7:0] e);
	comparisons++;
	if (s !== e)
	begin
		n_errors++;
		$display("Error at %0t: seen %h expected %h", $time, s, e);
	end
endtask
task automatic rd(input logic [7:0] a, input logic [7:0] e);
	logic [7:0] q;
	u_host.acc(1'b0, a, 8'h00, q);
	chk(q, e);
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	logic [7:0] q;
	u_host.acc(1'b1, a, d, q);
endtask
// bit 32 wake timeout, then main, timer/field, error/wake, target
task automatic pulse(input logic [32:0] v);
	@(posedge clk);
	{events.wake_timeout, events.main_ev, events.tf_ev, events.ew_ev, events.pt_ev} <= v;
	@(posedge clk);
	{events.wake_timeout, events.main_ev, events.tf_ev, events.ew_ev, events.pt_ev} <= 33'h0;
	@(posedge clk);
endtask
always @(posedge clk)
begin
	cycles++;
	if (cycles == 3000)
	begin
		n_errors++;
		end_sim;
	end
end
////////////////
initial
begin
	repeat (6) @(posedge clk);
	nrst <= 1'b1;
	repeat (3) @(posedge clk);
	rd(8'h68, 8'h00);
	rd(8'h6C, 8'h00);
	rd(8'h74, 8'h00);
	rd(8'hFC, 8'h00);
	$display("test reset done");
	pulse(33'h000FF0000);
	chk({7'h00, irq}, 8'h01);
	rd(8'h6C, 8'hFF);
	chk({7'h00, irq}, 8'h00);
	rd(8'h6C, 8'h00);
	events.slots_unused <= 8'h04;
	pulse(33'h0000000FF);
	rd(8'h74, 8'hFB);
	rd(8'h74, 8'h00);
	$display("test timer and target done");
	pulse(33'h0FF00FF00);
	rd(8'h70, 8'hF6);
	rd(8'h70, 8'hF6);
	rd(8'h68, 8'h3E);
	rd(8'h70, 8'h00);
	wr(8'hC0, 8'h01);
	events.osc_stable <= 1'b1;
	events.rx_active <= 1'b1;
	events.fifo_count <= 10'h12C;
	rd(8'h68, 8'h80);
	events.fifo_count <= 10'h12D;
	rd(8'h68, 8'h40);
	events.rx_active <= 1'b0;
	events.tx_active <= 1'b1;
	events.fifo_count <= 10'h0C8;
	rd(8'h68, 8'h00);
	events.fifo_count <= 10'h0C7;
	rd(8'h68, 8'h40);
	$display("test main and error done");
	pulse(33'h100000000);
	rd(8'h70, 8'h00);
	wr(8'hC0, 8'h03);
	pulse(33'h100000000);
	rd(8'h70, 8'h08);
	rd(8'h68, 8'h00);
	rd(8'h70, 8'h00);
	wr(8'h5C, 8'hFF);
	rd(8'h5C, 8'hFF);
	pulse(33'h000800000);
	chk({7'h00, irq}, 8'h00);
	rd(8'h6C, 8'h80);
	// masks of the other three registers; reserved mask bits read zero
	wr(8'h58, 8'hFF);
	rd(8'h58, 8'hFE);
	wr(8'h60, 8'hFF);
	rd(8'h60, 8'hFE);
	wr(8'h64, 8'hFF);
	rd(8'h64, 8'hFB);
	rd(8'hC0, 8'h03);
	pulse(33'h0FFFFFFFF);
	chk({7'h00, irq}, 8'h00);
	// unmasking a pending flag raises irq without a new event
	wr(8'h64, 8'h00);
	chk({7'h00, irq}, 8'h01);
	rd(8'h74, 8'hBB);
	chk({7'h00, irq}, 8'h00);
	rd(8'h70, 8'hF6);
	// a write to a flag register must leave it untouched
	wr(8'h68, 8'h00);
	rd(8'h68, 8'h3E);
	rd(8'h70, 8'h00);
	rd(8'h6C, 8'hFF);
	$display("test wake and mask done");
	end_sim;
end
endmodule // ris_top_test
